// File: hdl/cpus_pkg.sv
// Purpose: constants and types of the charger power-up sequencer
// Assumes: 200 MHz core clock
// Notes: times are kept in their own unit, cycle counts derived
package cpus_pkg;
  // ====================================================
  // clock rates and dividers
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned F_DIG_HZ = 500_000;
  localparam int unsigned F_LPDIG_HZ = 30_000;
  localparam int unsigned DIG_DIV = CLK_HZ / F_DIG_HZ;
  localparam int unsigned LP_DIV = CLK_HZ / F_LPDIG_HZ;
  localparam int unsigned DIG_PER_MS = F_DIG_HZ / 1000;
  localparam int unsigned LP_PER_MS = F_LPDIG_HZ / 1000;
  localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
  localparam int unsigned TW = 26;
  // ====================================================
  // timing
  localparam int unsigned T_BIAS_DLY_MS = 220;
  localparam int unsigned T_BADSRC_MS = 30;
  localparam int unsigned T_RETRY_S = 2;
  localparam int unsigned T_RETRY_MS = T_RETRY_S * 1000;
  localparam int unsigned T_RETRY_GAP_MS = T_RETRY_MS - T_BADSRC_MS;
  localparam int unsigned T_TERM_DGL_MS = 250;
  localparam int unsigned T_RECHG_DGL_MS = 250;
  localparam int unsigned T_SYSOVLD_US = 100;
  localparam int unsigned T_BATOVP_US = 1;
  localparam int unsigned T_SAFETY_HR = 10;
  localparam int unsigned T_SAFETY_MS = T_SAFETY_HR * 3_600_000;
  localparam int unsigned T_TOPOFF_MIN = 30;
  localparam int unsigned T_TOPOFF_MS = T_TOPOFF_MIN * 60_000;
  localparam int unsigned T_BTN_EXIT_MS = 1000;
  localparam int unsigned T_BTN_RST_MS = 10_000;
  localparam int unsigned T_BATSW_RST_MS = 300;
  localparam int unsigned T_SM_DLY_MS = 12_000;
  localparam int unsigned T_INT_US = 100;
  // ====================================================
  // register map
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_ILIM = 8'h08;
  localparam logic [4:0] CTL_RST = 5'h03;
  localparam logic [4:0] ILIM_RST = 5'h04;
  localparam int unsigned CTL_CHG_EN = 0;
  localparam int unsigned CTL_TMR_SEL = 1;
  localparam int unsigned CTL_TOPOFF_LO = 2;
  localparam int unsigned CTL_SHIP_REQ = 4;
  localparam logic [1:0] TOPOFF_30MIN = 2'h2;
  // ====================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_DLY = 3'h1,
    ST_QUAL = 3'h3,
    ST_DET = 3'h2,
    ST_VLIM = 3'h6,
    ST_RUN = 3'h4,
    ST_RETRY = 3'h7
  } cpus_state_t;
endpackage

// File: hdl/cpus_top.sv
// Purpose: power-up sequencer, timers and switch control of the charger
// Assumes: comparator levels are asynchronous, detector logic is on CORE_CLK
// Notes: ms and s timers run from the digital tick, slow tick when bias is off
// Summary of operation
// - supply release enables comparators, clears registers
// - battery only: switch closed, bias off
// - discharge overcurrent opens switch, sets disable
// - source bring-up runs in strict order
// - bias on after present, margin, 220 ms
// - any condition false: high impedance, bias off
// - qualify source with test load drawn
// - qualification pass sets input good, pulses
// - failed qualification retried every 2 s
// - type detection only after input good
// - detection done: pulse, limit, power good, type
// - bad source phase timed 30 ms
// - termination deglitched 250 ms
// - recharge deglitched 250 ms
// - system overcurrent deglitched 100 us
// - battery overvoltage deglitched 1 us
// - safety select set: fast charge ends 10 h
// - top-off field 10: 30 min top-off
// - button low about 1 s exits ship
// - button low 10 s resets battery switch
// - switch reset keeps switch open 300 ms
// - ship entry delayed 12 s after request
module cpus_dgl #(
  parameter int unsigned W = 26,
  parameter int unsigned LIM = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic cond,
  output logic hit
);
  logic [W-1:0] cnt_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else if (!cond) begin
      cnt_ff <= '0;
    end else if (tick && cnt_ff != W'(LIM)) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign hit = cond && (cnt_ff == W'(LIM));
endmodule // cpus_dgl

module cpus_top import cpus_pkg::*; #(
  parameter int unsigned P_DIG_DIV = DIG_DIV,
  parameter int unsigned P_LP_DIV = LP_DIV,
  parameter int unsigned P_DIG_PER_MS = DIG_PER_MS,
  parameter int unsigned P_LP_PER_MS = LP_PER_MS,
  parameter int unsigned P_SAFETY_MS = T_SAFETY_MS,
  parameter int unsigned P_TOPOFF_MS = T_TOPOFF_MS,
  parameter int unsigned P_BTN_RST_MS = T_BTN_RST_MS,
  parameter int unsigned P_SM_DLY_MS = T_SM_DLY_MS
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // analog comparators
  input wire logic VBUS_UVLO_OK,
  input wire logic BAT_UVLO_OK,
  input wire logic BAT_DPL_OK,
  input wire logic INPUT_SENSE_PRESENT,
  input wire logic INPUT_SENSE_ABOVE_SLEEP,
  input wire logic VBUS_BELOW_OV,
  input wire logic VBUS_ABOVE_MIN,
  input wire logic BAT_OCP,
  input wire logic SYS_OVLD,
  input wire logic BAT_OVP,
  input wire logic TERM_COND,
  input wire logic RECHG_COND,
  input wire logic SHIP_EXIT_BUTTON_B,
  // detector and mode logic
  input wire logic BOOST_MODE,
  input wire logic DET_DONE,
  input wire logic [2:0] DET_TYPE,
  input wire logic [4:0] DET_ILIM,
  // control outputs
  output logic COMP_EN,
  output logic BIAS_REGULATOR_EN,
  output logic HIGH_IMPEDANCE_STATE,
  output logic SOURCE_TEST_LOAD_EN,
  output logic DET_START,
  output logic INPUT_VOLTAGE_LIMIT_SET,
  output logic CONV_EN,
  output logic BATTERY_SWITCH_ON,
  output logic CHG_EN,
  output logic [4:0] INPUT_CURRENT_LIMIT,
  // interrupt pin, open drain
  output logic INT_O,
  output logic INT_OE
);
  // ====================================================
  // parameter checks
  if (P_DIG_DIV < 1 || P_DIG_DIV > 65535 || P_LP_DIV < 1 || P_LP_DIV > 65535 ||
      P_DIG_PER_MS < 1 || P_LP_PER_MS < 1 || P_DIG_PER_MS > 65535 ||
      P_LP_PER_MS > 65535 || P_SAFETY_MS >= (1 << TW)) begin : g_bad
    $error("cpus_top: parameter out of range");
  end

  // ====================================================
  // input synchronisers
  localparam int unsigned NS = 13;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_ff;
  logic [NS-1:0] s2_ff;
  assign raw = {SHIP_EXIT_BUTTON_B, RECHG_COND, TERM_COND, BAT_OVP, SYS_OVLD, BAT_OCP,
                VBUS_ABOVE_MIN, VBUS_BELOW_OV, INPUT_SENSE_ABOVE_SLEEP,
                INPUT_SENSE_PRESENT, BAT_DPL_OK, BAT_UVLO_OK, VBUS_UVLO_OK};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        s1_ff[i] <= 1'b0;
        s2_ff[i] <= 1'b0;
      end else begin
        s1_ff[i] <= raw[i];
        s2_ff[i] <= s1_ff[i];
      end
    end
  end
  logic por_ok, bat_dpl, in_present, in_above, below_ov, above_min;
  logic ocp, sysovld, batovp, term_c, rechg_c, btn_low;
  assign por_ok = s2_ff[0] | s2_ff[1];
  assign bat_dpl = s2_ff[2];
  assign in_present = s2_ff[3];
  assign in_above = s2_ff[4];
  assign below_ov = s2_ff[5];
  assign above_min = s2_ff[6];
  assign ocp = s2_ff[7];
  assign sysovld = s2_ff[8];
  assign batovp = s2_ff[9];
  assign term_c = s2_ff[10];
  assign rechg_c = s2_ff[11];
  assign btn_low = !s2_ff[12];

  logic por_clr;
  assign por_clr = !por_ok;
  assign COMP_EN = por_ok;

  // ====================================================
  // tick generation
  cpus_state_t st_ff, nxt_st;
  logic bias_on, dig_tick, ms_tick, us_tick;
  logic [15:0] div_ff, ms_div_ff, div_lim, ms_lim;
  logic [7:0] us_ff;
  // slow tick while bias is off
  assign div_lim = bias_on ? 16'(P_DIG_DIV - 1) : 16'(P_LP_DIV - 1);
  assign ms_lim = bias_on ? 16'(P_DIG_PER_MS - 1) : 16'(P_LP_PER_MS - 1);
  assign dig_tick = div_ff >= div_lim;
  assign ms_tick = dig_tick && (ms_div_ff >= ms_lim);
  assign us_tick = us_ff == 8'(US_CYC - 1);
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_ff <= 16'h0000;
      ms_div_ff <= 16'h0000;
    end else begin
      div_ff <= dig_tick ? 16'h0000 : div_ff + 16'h0001;
      if (ms_tick) begin
        ms_div_ff <= 16'h0000;
      end else if (dig_tick) begin
        ms_div_ff <= ms_div_ff + 16'h0001;
      end
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      us_ff <= 8'h00;
    end else begin
      us_ff <= us_tick ? 8'h00 : us_ff + 8'h01;
    end
  end

  // ====================================================
  // source bring-up sequencer
  logic bias_ok, qual_bad_ff, qual_pass, det_end;
  logic [TW-1:0] st_tmr_ff;
  // present, margin (or below in boost)
  assign bias_ok = in_present && (BOOST_MODE ? !in_above : in_above);
  always_comb begin
    nxt_st = st_ff;
    qual_pass = 1'b0;
    det_end = 1'b0;
    if (!bias_ok) begin
      nxt_st = ST_OFF;
    end else begin
      case (st_ff)
        ST_OFF: nxt_st = ST_DLY;
        ST_DLY: if (st_tmr_ff >= TW'(T_BIAS_DLY_MS)) nxt_st = ST_QUAL;
        ST_QUAL: if (st_tmr_ff >= TW'(T_BADSRC_MS)) begin
          if (qual_bad_ff) begin
            nxt_st = ST_RETRY;
          end else begin
            nxt_st = ST_DET;
            qual_pass = 1'b1;
          end
        end
        ST_RETRY: if (st_tmr_ff >= TW'(T_RETRY_GAP_MS)) nxt_st = ST_QUAL;
        ST_DET: if (DET_DONE) begin
          nxt_st = ST_VLIM;
          det_end = 1'b1;
        end
        ST_VLIM: nxt_st = ST_RUN;
        ST_RUN: nxt_st = ST_RUN;
        default: nxt_st = ST_OFF;
      endcase
    end
    if (por_clr) begin
      nxt_st = ST_OFF;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= ST_OFF;
      st_tmr_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      if (nxt_st != st_ff) begin
        st_tmr_ff <= '0;
      end else if (ms_tick && st_tmr_ff != '1) begin
        st_tmr_ff <= st_tmr_ff + 1'b1;
      end
    end
  end
  // pass needs both limits for the whole phase
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      qual_bad_ff <= 1'b0;
    end else if (st_ff != ST_QUAL) begin
      qual_bad_ff <= 1'b0;
    end else if (!(below_ov && above_min)) begin
      qual_bad_ff <= 1'b1;
    end
  end
  assign bias_on = !(st_ff == ST_OFF || st_ff == ST_DLY);
  assign BIAS_REGULATOR_EN = bias_on;
  assign HIGH_IMPEDANCE_STATE = !bias_on;
  assign SOURCE_TEST_LOAD_EN = st_ff == ST_QUAL;
  // detection after input good, bias up
  assign DET_START = st_ff == ST_DET;
  assign INPUT_VOLTAGE_LIMIT_SET = st_ff == ST_VLIM;
  assign CONV_EN = st_ff == ST_RUN;

  // ====================================================
  // status flags and interrupt pulse
  logic input_good_flag_ff, power_good_flag_ff;
  logic [2:0] source_type_field_ff;
  logic [4:0] ilim_ff, ctl_ff;
  logic [6:0] int_ff;
  logic wr_ilim, wr_ctl;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      input_good_flag_ff <= 1'b0;
      power_good_flag_ff <= 1'b0;
      source_type_field_ff <= 3'h0;
      ilim_ff <= ILIM_RST;
    end else if (por_clr) begin
      input_good_flag_ff <= 1'b0;
      power_good_flag_ff <= 1'b0;
      source_type_field_ff <= 3'h0;
      ilim_ff <= ILIM_RST;
    end else begin
      if (wr_ilim) begin
        ilim_ff <= HWDATA[4:0];
      end
      if (st_ff == ST_OFF) begin
        input_good_flag_ff <= 1'b0;
        power_good_flag_ff <= 1'b0;
      end
      if (qual_pass) begin
        input_good_flag_ff <= 1'b1;
      end
      if (det_end) begin
        ilim_ff <= DET_ILIM;
        power_good_flag_ff <= 1'b1;
        source_type_field_ff <= DET_TYPE;
      end
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      int_ff <= 7'h00;
    end else if (qual_pass || det_end) begin
      int_ff <= 7'(T_INT_US);
    end else if (us_tick && int_ff != 7'h00) begin
      int_ff <= int_ff - 7'h01;
    end
  end
  assign INT_O = 1'b0;
  assign INT_OE = int_ff != 7'h00;
  assign INPUT_CURRENT_LIMIT = ilim_ff;

  // ====================================================
  // charge timers
  logic done_ff, topoff_ff, safety_exp_ff, chg_allow;
  logic term_hit, rechg_hit, topoff_hit, safety_hit, batovp_hit;
  assign chg_allow = (st_ff == ST_RUN) && ctl_ff[CTL_CHG_EN] && !done_ff &&
                     !safety_exp_ff && !batovp_hit;
  assign CHG_EN = chg_allow;
  cpus_dgl #(.W(TW), .LIM(T_TERM_DGL_MS)) u_term (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(ms_tick), .cond(chg_allow && !topoff_ff && term_c), .hit(term_hit));
  cpus_dgl #(.W(TW), .LIM(T_RECHG_DGL_MS)) u_rechg (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(ms_tick), .cond(done_ff && rechg_c), .hit(rechg_hit));
  cpus_dgl #(.W(TW), .LIM(P_TOPOFF_MS)) u_topoff (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(ms_tick), .cond(topoff_ff && chg_allow), .hit(topoff_hit));
  cpus_dgl #(.W(TW), .LIM(P_SAFETY_MS)) u_safety (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(ms_tick), .cond(chg_allow && !topoff_ff && ctl_ff[CTL_TMR_SEL]),
    .hit(safety_hit));
  cpus_dgl #(.W(8), .LIM(T_BATOVP_US)) u_batovp (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(us_tick), .cond(batovp), .hit(batovp_hit));
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      done_ff <= 1'b0;
      topoff_ff <= 1'b0;
      safety_exp_ff <= 1'b0;
    end else if (por_clr || st_ff != ST_RUN) begin
      done_ff <= 1'b0;
      topoff_ff <= 1'b0;
      safety_exp_ff <= 1'b0;
    end else begin
      if (rechg_hit) begin
        done_ff <= 1'b0;
      end
      if (term_hit) begin
        if (ctl_ff[CTL_TOPOFF_LO+1:CTL_TOPOFF_LO] == TOPOFF_30MIN) begin
          topoff_ff <= 1'b1;
        end else begin
          done_ff <= 1'b1;
        end
      end
      if (topoff_hit) begin
        topoff_ff <= 1'b0;
        done_ff <= 1'b1;
      end
      if (safety_hit) begin
        safety_exp_ff <= 1'b1;
      end
    end
  end

  // ====================================================
  // battery switch, ship mode and button
  logic dis_ff, ship_ff, rst_off_ff, in_d_ff, exit_d_ff, brst_d_ff;
  logic sysovld_hit, ship_hit, exit_hit, brst_hit, rst_done_hit;
  logic in_rise, exit_ev, brst_ev;
  cpus_dgl #(.W(8), .LIM(T_SYSOVLD_US)) u_sysovld (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(us_tick), .cond(sysovld), .hit(sysovld_hit));
  cpus_dgl #(.W(TW), .LIM(P_SM_DLY_MS)) u_ship (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(ms_tick), .cond(ctl_ff[CTL_SHIP_REQ]), .hit(ship_hit));
  cpus_dgl #(.W(TW), .LIM(T_BTN_EXIT_MS)) u_exit (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(ms_tick), .cond(btn_low), .hit(exit_hit));
  cpus_dgl #(.W(TW), .LIM(P_BTN_RST_MS)) u_brst (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(ms_tick), .cond(btn_low), .hit(brst_hit));
  cpus_dgl #(.W(TW), .LIM(T_BATSW_RST_MS)) u_roff (.clk(CORE_CLK), .rst_b(RST_B),
    .tick(ms_tick), .cond(rst_off_ff), .hit(rst_done_hit));
  assign in_rise = in_present && !in_d_ff;
  assign exit_ev = exit_hit && !exit_d_ff;
  assign brst_ev = brst_hit && !brst_d_ff;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      in_d_ff <= 1'b0;
      exit_d_ff <= 1'b0;
      brst_d_ff <= 1'b0;
    end else begin
      in_d_ff <= in_present;
      exit_d_ff <= exit_hit;
      brst_d_ff <= brst_hit;
    end
  end
  // set terms last so a new fault beats a clear
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dis_ff <= 1'b0;
      ship_ff <= 1'b0;
      rst_off_ff <= 1'b0;
    end else if (por_clr) begin
      dis_ff <= 1'b0;
      ship_ff <= 1'b0;
      rst_off_ff <= 1'b0;
    end else begin
      if (in_rise || exit_ev) begin
        dis_ff <= 1'b0;
        ship_ff <= 1'b0;
      end
      if (ocp || sysovld_hit) begin
        dis_ff <= 1'b1;
      end
      if (ship_hit) begin
        ship_ff <= 1'b1;
      end
      if (rst_done_hit) begin
        rst_off_ff <= 1'b0;
      end
      if (brst_ev) begin
        rst_off_ff <= 1'b1;
      end
    end
  end
  assign BATTERY_SWITCH_ON = bat_dpl && !dis_ff && !ocp && !ship_ff && !rst_off_ff;

  // ====================================================
  // ahb-lite register slave
  logic ph_ff, ph_wr_ff;
  logic [7:0] ph_addr_ff;
  logic [31:0] rdata_ff, rd_mux;
  logic acc;
  assign acc = HSEL && HREADY && HTRANS[1];
  assign wr_ctl = ph_ff && ph_wr_ff && ph_addr_ff == OFF_CONTROL;
  assign wr_ilim = ph_ff && ph_wr_ff && ph_addr_ff == OFF_ILIM;
  always_comb begin
    rd_mux = 32'h00000000;
    case ({HADDR[7:2], 2'b00})
      OFF_STATUS: rd_mux = {17'h0, 3'(st_ff), 1'b0, !bias_on, safety_exp_ff, done_ff,
                            chg_allow, ship_ff, dis_ff, source_type_field_ff,
                            power_good_flag_ff, input_good_flag_ff};
      OFF_CONTROL: rd_mux = {27'h0, ctl_ff};
      OFF_ILIM: rd_mux = {27'h0, ilim_ff};
      default: rd_mux = 32'h00000000;
    endcase
    if (HADDR[31:8] != 24'h000000) begin
      rd_mux = 32'h00000000;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ph_ff <= 1'b0;
      ph_wr_ff <= 1'b0;
      ph_addr_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
    end else if (HREADY) begin
      ph_ff <= acc && HADDR[31:8] == 24'h000000;
      ph_wr_ff <= HWRITE;
      ph_addr_ff <= {HADDR[7:2], 2'b00};
      if (acc && !HWRITE) begin
        rdata_ff <= rd_mux;
      end
    end
  end
  // hardware clears the ship request; a bus write in the same cycle wins
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_ff <= CTL_RST;
    end else if (por_clr) begin
      ctl_ff <= CTL_RST;
    end else if (wr_ctl) begin
      ctl_ff <= HWDATA[4:0];
    end else if (ship_hit) begin
      ctl_ff[CTL_SHIP_REQ] <= 1'b0;
    end
  end
  assign HRDATA = rdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
endmodule // cpus_top

// File: verification/cpus_assertions.sv
// Purpose: concurrent checks on the sequencer top ports
// Assumes: one CORE_CLK domain, RST_B asynchronous active low
// Notes: bound to cpus_top from the testbench top file
module cpus_assertions (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // inputs watched
  input wire logic VBUS_UVLO_OK,
  input wire logic BAT_UVLO_OK,
  input wire logic INPUT_SENSE_PRESENT,
  input wire logic BAT_OCP,
  input wire logic DET_DONE,
  input wire logic [4:0] DET_ILIM,
  // outputs watched
  input wire logic COMP_EN,
  input wire logic BIAS_REGULATOR_EN,
  input wire logic HIGH_IMPEDANCE_STATE,
  input wire logic SOURCE_TEST_LOAD_EN,
  input wire logic DET_START,
  input wire logic INPUT_VOLTAGE_LIMIT_SET,
  input wire logic CONV_EN,
  input wire logic BATTERY_SWITCH_ON,
  input wire logic [4:0] INPUT_CURRENT_LIMIT,
  input wire logic INT_OE
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  // ====================================================
  // detection steps
  sequence det_end_s;
    DET_START && DET_DONE;
  endsequence
  sequence vlim_run_s;
    INPUT_VOLTAGE_LIMIT_SET ##1 CONV_EN;
  endsequence
  // ====================================================
  // checks
  a_comp_off: assert property ((!VBUS_UVLO_OK && !BAT_UVLO_OK) [*3] |-> !COMP_EN)
    else $error("comparators on without supply");
  a_hiz_inverse: assert property (HIGH_IMPEDANCE_STATE != BIAS_REGULATOR_EN)
    else $error("high impedance not inverse of bias");
  a_bias_present: assert property (!INPUT_SENSE_PRESENT [*4] |-> !BIAS_REGULATOR_EN)
    else $error("bias on without input");
  a_load_bias: assert property (SOURCE_TEST_LOAD_EN |-> BIAS_REGULATOR_EN && !DET_START)
    else $error("test load outside qualification");
  a_det_order: assert property ($rose(DET_START) |-> $past(SOURCE_TEST_LOAD_EN))
    else $error("detection without qualification");
  a_vlim_order: assert property (det_end_s |=> vlim_run_s)
    else $error("limit set or converter out of order");
  a_ilim_load: assert property (det_end_s |-> ##2 INPUT_CURRENT_LIMIT == $past(DET_ILIM, 2))
    else $error("current limit not loaded");
  a_int_pass: assert property ($rose(DET_START) |-> ##[0:2] INT_OE)
    else $error("no interrupt on qualification");
  a_int_det: assert property (det_end_s |-> ##[1:3] INT_OE)
    else $error("no interrupt on detection");
  a_ocp_open: assert property (BAT_OCP |-> ##[1:4] !BATTERY_SWITCH_ON)
    else $error("switch not opened on overcurrent");
endmodule // cpus_assertions

// File: verification/cpus_det_model.sv
// Purpose: source type detector and interrupt pull-up beside the sequencer
// Assumes: same clock as the sequencer
// Notes: answer latency set by LAT, data inverted when not valid
module cpus_det_model #(
  parameter int unsigned LAT = 20,
  parameter logic [2:0] TYPE = 3'h5,
  parameter logic [4:0] ILIM = 5'h13
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // detector handshake
  input wire logic det_start,
  output logic det_done,
  output logic [2:0] det_type,
  output logic [4:0] det_ilim,
  // interrupt line
  input wire logic int_o,
  input wire logic int_oe,
  output logic int_b
);
  int unsigned cnt_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 0;
    end else if (!det_start) begin
      cnt_ff <= 0;
    end else if (cnt_ff < LAT) begin
      cnt_ff <= cnt_ff + 1;
    end
  end
  assign det_done = det_start && (cnt_ff == LAT - 1);
  assign det_type = det_done ? TYPE : ~TYPE;
  assign det_ilim = det_done ? ILIM : ~ILIM;
  assign int_b = int_oe ? int_o : 1'b1;
endmodule // cpus_det_model

// File: verification/cpus_top_test.sv
// Purpose: self-checking bench of the power-up sequencer
// Assumes: shortened tick dividers, bus master tasks on AHB-Lite
// Notes: timings checked within two ms either side, retry gap up to 32 ms above
module cpus_top_test import cpus_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DD = 2;
  localparam int LD = 3;
  localparam int PM = 2;
  localparam int DGT = DD * PM;
  localparam int LPT = LD * PM;
  localparam logic [2:0] DT = 3'h5;
  localparam logic [4:0] DI = 5'h13;
  logic clk, rst_b, hwrite, vuv, buv, dpl, pres, abv, bov, bmin, ocp, sov, boost, int_seen;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic hrdy, comp, bias, high_impedance_state, load, dst, conv, bsw, int_o, int_oe, int_b, ddone;
  logic [2:0] dtype;
  logic [4:0] dilim, ilim;
  logic btn, hresp, chg, vls;
  int fail_count, num_checks;
  cpus_top #(.P_DIG_DIV(DD), .P_LP_DIV(LD), .P_DIG_PER_MS(PM), .P_LP_PER_MS(PM),
    .P_SAFETY_MS(50), .P_TOPOFF_MS(20), .P_BTN_RST_MS(1200), .P_SM_DLY_MS(30)) u_dut (
    .CORE_CLK(clk), .RST_B(rst_b), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .VBUS_UVLO_OK(vuv), .BAT_UVLO_OK(buv), .BAT_DPL_OK(dpl),
    .INPUT_SENSE_PRESENT(pres), .INPUT_SENSE_ABOVE_SLEEP(abv), .VBUS_BELOW_OV(bov),
    .VBUS_ABOVE_MIN(bmin), .BAT_OCP(ocp), .SYS_OVLD(sov), .BAT_OVP(1'b0), .TERM_COND(1'b0),
    .RECHG_COND(1'b0), .SHIP_EXIT_BUTTON_B(btn), .BOOST_MODE(boost), .DET_DONE(ddone),
    .DET_TYPE(dtype), .DET_ILIM(dilim), .COMP_EN(comp), .BIAS_REGULATOR_EN(bias),
    .HIGH_IMPEDANCE_STATE(high_impedance_state), .SOURCE_TEST_LOAD_EN(load), .DET_START(dst),
    .INPUT_VOLTAGE_LIMIT_SET(vls), .CONV_EN(conv), .BATTERY_SWITCH_ON(bsw), .CHG_EN(chg),
    .INPUT_CURRENT_LIMIT(ilim), .INT_O(int_o), .INT_OE(int_oe));
  cpus_det_model #(.LAT(20), .TYPE(DT), .ILIM(DI)) u_det (.clk(clk), .rst_b(rst_b),
    .det_start(dst), .det_done(ddone), .det_type(dtype), .det_ilim(dilim), .int_o(int_o),
    .int_oe(int_oe), .int_b(int_b));
  // ====================================================
  // clock, start values, interrupt watch
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst_b, hwrite, vuv, buv, dpl, pres, abv, bmin, ocp, sov, boost, int_seen} = '0;
    {bov, htrans, haddr, hwdata, fail_count, num_checks} = '0;
    {bov, btn} = 2'h3;
  end
  always @(negedge int_b) int_seen = 1'b1;
  // ====================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return load;
      1: return !load;
      default: return vls;
    endcase
  endfunction
  task automatic wait_for(input int s, output int n);
    n = 0;
    while (pick(s) !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic [31:0] inr(input int n, lo, hi);
    return 32'(n >= lo && n <= hi);
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ====================================================
  // main sequence
  initial begin
    int n;
    logic [31:0] r;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    buv <= 1'b1;
    dpl <= 1'b1;
    repeat (4) @(posedge clk);
    chk("comp_en", 32'(comp), 32'h1);
    chk("switch_on", 32'({bsw, high_impedance_state, bias, hresp}), 32'hc);
    xfer(1'b0, 32'(OFF_CONTROL), 32'h0, r);
    chk("control", r, 32'(CTL_RST));
    xfer(1'b0, 32'(OFF_ILIM), 32'h0, r);
    chk("ilim", r, 32'(ILIM_RST));
    xfer(1'b1, 32'(OFF_CONTROL), 32'h0000000b, r);
    xfer(1'b0, 32'(OFF_CONTROL), 32'h0, r);
    chk("control_wr", r, 32'h0000000b);
    xfer(1'b0, 32'h0000000c, 32'h0, r);
    chk("unmapped", r, 32'h0);
    sov <= 1'b1;
    repeat (40) @(posedge clk);
    sov <= 1'b0;
    chk("ovld_glitch", 32'(bsw), 32'h1);
    ocp <= 1'b1;
    repeat (3) @(posedge clk);
    ocp <= 1'b0;
    repeat (4) @(posedge clk);
    chk("ocp_open", 32'(bsw), 32'h0);
    xfer(1'b0, 32'(OFF_STATUS), 32'h0, r);
    chk("sw_disable", 32'(r[5]), 32'h1);
    {vuv, pres, abv} <= 3'h7;
    wait_for(0, n);
    chk("bias_delay", inr(n, (T_BIAS_DLY_MS - 2) * LPT, (T_BIAS_DLY_MS + 2) * LPT + 8), 32'h1);
    chk("bias_on", 32'({bias, high_impedance_state}), 32'h2);
    wait_for(1, n);
    wait_for(0, n);
    chk("retry", inr(n, (T_RETRY_GAP_MS - 2) * DGT, (T_RETRY_MS + 2) * DGT), 32'h1);
    wait_for(1, n);
    repeat (7000) @(posedge clk);
    bmin <= 1'b1;
    wait_for(0, n);
    wait_for(1, n);
    chk("qual_len", inr(n, (T_BADSRC_MS - 2) * DGT, (T_BADSRC_MS + 2) * DGT + 8), 32'h1);
    chk("det_start", 32'(dst), 32'h1);
    xfer(1'b0, 32'(OFF_STATUS), 32'h0, r);
    chk("input_good", 32'(r[0]), 32'h1);
    wait_for(2, n);
    xfer(1'b0, 32'(OFF_STATUS), 32'h0, r);
    chk("status", r & 32'h0000701f, {17'h0, ST_RUN, 7'h0, DT, 2'h3});
    xfer(1'b0, 32'(OFF_ILIM), 32'h0, r);
    chk("ilim_det", {r[26:0], ilim}, {22'h0, DI, DI});
    chk("int_pulse", 32'(int_seen), 32'h1);
    chk("switch_back", 32'({bsw, chg, conv}), 32'h7);
    btn <= 1'b0;
    repeat (5000) @(posedge clk);
    chk("btn_reset", 32'({bsw, chg}), 32'h0);
    btn <= 1'b1;
    repeat (1300) @(posedge clk);
    chk("reset_end", 32'(bsw), 32'h1);
    boost <= 1'b1;
    repeat (4) @(posedge clk);
    chk("boost_hiz", 32'({bias, high_impedance_state, conv}), 32'h2);
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule // cpus_top_test

bind cpus_top cpus_assertions u_chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .VBUS_UVLO_OK(VBUS_UVLO_OK), .BAT_UVLO_OK(BAT_UVLO_OK), .BAT_OCP(BAT_OCP),
  .INPUT_SENSE_PRESENT(INPUT_SENSE_PRESENT), .DET_DONE(DET_DONE), .DET_ILIM(DET_ILIM),
  .COMP_EN(COMP_EN), .BIAS_REGULATOR_EN(BIAS_REGULATOR_EN), .DET_START(DET_START),
  .HIGH_IMPEDANCE_STATE(HIGH_IMPEDANCE_STATE), .SOURCE_TEST_LOAD_EN(SOURCE_TEST_LOAD_EN),
  .INPUT_VOLTAGE_LIMIT_SET(INPUT_VOLTAGE_LIMIT_SET), .CONV_EN(CONV_EN), .INT_OE(INT_OE),
  .BATTERY_SWITCH_ON(BATTERY_SWITCH_ON), .INPUT_CURRENT_LIMIT(INPUT_CURRENT_LIMIT));
